// [verif/arb_node_sequencer_assertions.sv]
`timescale 1ns/1ps
module arb_node_sequencer_assertions
    import arb_seq_pkg::*;
#(
    parameter int unsigned TICK_COUNT = 40
) (
    input wire logic                           clock,         // Clock
    input wire logic                           reset_n,       // Reset
    input wire logic                           start,         // Run
    input wire logic                           stop,          // Halt
    input wire logic                           repeatOn,      // Repeat
    input wire logic [arb_seq_pkg::VOLT_W-1:0] setpoint,      // Value
    input wire logic                           setpointValid, // Valid
    input wire logic                           setpointReady, // Taken
    input wire logic                           running,       // Active
    input wire logic [arb_seq_pkg::IDX_W-1:0]  nodePosition   // Node
);
    localparam int DLO = TICK_COUNT - 8;
    localparam int DHI = TICK_COUNT - 3;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////
    // Run control and stream
    chk_reset_idle: assert property ($rose(reset_n) |-> !running
        && !setpointValid && nodePosition == FIRST_NODE)
        else $error("outputs not idle after reset");
    chk_start_runs: assert property (start && !stop |=> running)
        else $error("start did not run");
    chk_stop_halts: assert property (stop |-> ##[1:2] !running)
        else $error("stop did not halt");
    chk_value_holds: assert property (setpointValid && !setpointReady
        |=> setpointValid && $stable(setpoint))
        else $error("setpoint changed while waiting");
    chk_index_range: assert property (nodePosition <= LAST_NODE)
        else $error("node index past last position");
    // Without repeat the index may only move forward by one
    chk_index_step: assert property (running && $past(running)
        && !$past(start) && !repeatOn && $changed(nodePosition)
        |-> nodePosition == $past(nodePosition) + 6'h01)
        else $error("node index skipped");
    chk_idle_quiet: assert property ((!running && !setpointValid
        && !start)[*3] |=> !setpointValid)
        else $error("setpoint while halted");
    // First value comes one tick after start, not earlier
    chk_first_tick: assert property (start && !stop && !running
        && !setpointValid |=> (!setpointValid)[*8] ##[DLO:DHI] setpointValid)
        else $error("first setpoint off tick");
    cover property ($rose(running));
    cover property (stop && running);
    cover property ((setpointValid && !setpointReady)[*8]);
endmodule : arb_node_sequencer_assertions

bind arb_node_sequencer arb_node_sequencer_assertions #(
    .TICK_COUNT(TICK_COUNT)) chk_u (.clock, .reset_n, .start, .stop,
    .repeatOn, .setpoint, .setpointValid, .setpointReady, .running,
    .nodePosition);

// [verif/arb_node_sequencer_test.sv]
`timescale 1ns/1ps
module arb_node_sequencer_test;
    import arb_seq_pkg::*;
    localparam int TC = 40; // Short tick keeps the run brief
    logic clock = 1'h0, reset_n = 1'h0, start = 1'h0, stop = 1'h0;
    logic repeatOn = 1'h0, rangeSel = 1'h0, restoreDefaults = 1'h0;
    logic wrEn = 1'h0, wrRange = 1'h0, hold = 1'h0;
    logic [IDX_W-1:0] startNode = 6'h00, wrNode = 6'h00, nodePosition;
    logic [VOLT_W-1:0] wrVoltage = 12'h000, setpoint, tv[2][60], q[$], e;
    logic [DUR_W-1:0] wrDuration = 12'h000, tt[2][60];
    logic setpointValid, setpointReady, running;
    int num_errors = 0, num_checks = 0, seed = 7742, k;

    always #2 clock = ~clock;
    arb_node_sequencer #(.TICK_COUNT(TC)) dut_u (.clock, .reset_n, .start,
        .stop, .repeatOn, .rangeSel, .startNode, .restoreDefaults, .wrEn,
        .wrRange, .wrNode, .wrVoltage, .wrDuration, .setpoint,
        .setpointValid, .setpointReady, .running, .nodePosition);
    regulator_model part_u (.clock, .reset_n, .setpoint, .setpointValid,
        .hold, .setpointReady);

    ////////////////////////////////////////////////////////////////////////
    task check(input string nm, input logic [VOLT_W-1:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    // Judge each word just before the edge that takes it
    always @(negedge clock) begin
        #1;
        if (reset_n && setpointValid === 1'h1 && setpointReady === 1'h1) begin
            e = q.size() ? q.pop_front() : ~setpoint;
            check("setpoint", setpoint, e);
        end
    end
    // Factory table shadow; all also clears 11 to 60
    task shadow(input bit all);
        for (int r = 0; r < 2; r++) for (int i = 0; i < 60; i++) begin
            if (i < 10) begin
                tv[r][i] = (i == 0 || i == 9) ? (r ? V_24_00 : V_12_00) :
                    (i < 3) ? (r ? V_8_00 : V_6_00) : (r ? V_12_00 : V_7_00);
                tt[r][i] = (i == 9) ? DUR_ZERO : (i == 0) ? (r ? T_10 : T_5)
                    : (i == 1) ? (r ? T_50 : T_15) : (i == 2) ? T_50
                    : (i == 8 && r) ? T_10 : T_100;
            end else if (all) begin
                tv[r][i] = VOLT_ZERO;
                tt[r][i] = DUR_ZERO;
            end
        end
    endtask : shadow
    // Queue expectations, then start
    task run(input bit r, input int s, input bit rep, input int lim);
        int i, n, d, a, v, m, b, g;
        i = s;
        n = 0;
        q.push_back(tv[r][i]);
        while (n < lim) begin
            d = tt[r][i];
            if (d == 0 && !rep) break;
            if (d == 0) begin
                i = s;
                q.push_back(tv[r][i]);
                n++;
                continue;
            end
            if (i == 59 && !rep) break;
            g = (i + 1) % 60;
            v = tv[r][i];
            m = int'(tv[r][g]) - v;
            b = m < 0 ? -m : m;
            a = 0;
            for (int j = 1; j <= d; j++) begin
                a += b % d;
                v += (m < 0 ? -1 : 1) * (b / d + (a >= d));
                if (a >= d) a -= d;
                q.push_back(j == d ? tv[r][g] : 12'(v));
                n++;
            end
            i = g;
        end
        @(negedge clock);
        rangeSel = r;
        startNode = 6'(s);
        repeatOn = rep;
        start = 1'h1;
        @(negedge clock);
        start = 1'h0;
    endtask : run
    // Wait for idle; a stopped run leaves an unmatched tail
    task settle(input bit all);
        for (k = 0; k < 40000 && (running !== 1'h0 || setpointValid !== 1'h0
            || (all && q.size() > 0)); k++) @(negedge clock);
        repeat (20) @(negedge clock);
        if (all) check("left", 12'(q.size()), 12'h000);
        q.delete();
    endtask : settle
    task halt(input int left);
        for (k = 0; k < 20000 && q.size() > left; k++) @(negedge clock);
        stop = 1'h1;
        @(negedge clock);
        stop = 1'h0;
        settle(1'h0);
    endtask : halt
    task wr(input bit r, input int i, input logic [VOLT_W-1:0] v,
            input logic [DUR_W-1:0] d);
        @(negedge clock);
        wrEn = 1'h1;
        wrRange = r;
        wrNode = 6'(i);
        wrVoltage = v;
        wrDuration = d;
        tv[r][i] = v;
        tt[r][i] = d;
    endtask : wr

    ////////////////////////////////////////////////////////////////////////
    initial begin
        shadow(1'h1);
        repeat (10) @(negedge clock);
        reset_n = 1'h1;
        // Factory low pulse; stall long enough to fill the buffer
        run(1'h0, 0, 1'h0, 9999);
        repeat (400) @(negedge clock);
        hold = 1'h1;
        repeat (1200) @(negedge clock);
        hold = 1'h0;
        settle(1'h1);
        // Second waveform, repeating
        wr(1'h0, 20, 12'h064, 12'h003);
        wr(1'h0, 21, 12'h078, 12'h002);
        wr(1'h0, 22, 12'h05a, DUR_ZERO);
        run(1'h0, 20, 1'h1, 20);
        halt(4);
        // High table, no terminal node
        for (int i = 0; i < 60; i++)
            wr(1'h1, i, 12'($unsigned($random(seed)) % 2048),
                12'(1 + $unsigned($random(seed)) % 3));
        @(negedge clock);
        wrEn = 1'h0;
        run(1'h1, 57, 1'h0, 9999);
        settle(1'h1);
        run(1'h1, 58, 1'h1, 40);
        halt(4);
        // Restore rewrites only the pulse; upper nodes stay random
        restoreDefaults = 1'h1;
        @(negedge clock);
        restoreDefaults = 1'h0;
        shadow(1'h0);
        run(1'h1, 0, 1'h0, 9999);
        settle(1'h1);
        final_report();
    end
    initial begin
        repeat (95000) @(posedge clock);
        num_errors++;
        final_report();
    end
endmodule : arb_node_sequencer_test

// [verif/regulator_model.sv]
`timescale 1ns/1ps
module regulator_model (
    input wire logic                           clock,         // Clock
    input wire logic                           reset_n,       // Reset
    input wire logic [arb_seq_pkg::VOLT_W-1:0] setpoint,      // Value
    input wire logic                           setpointValid, // Valid
    input wire logic                           hold,          // Stall
    output logic                               setpointReady  // Taken
);
    int seed = 7742;
    ////////////////////////////////////////////////////////////////////////
    // Ready moves off the sampling edge
    always @(negedge clock or negedge reset_n) begin
        if (!reset_n)
            setpointReady <= 1'h0;
        else
            setpointReady <= !hold && ($random(seed) % 4 != 0);
    end
endmodule : regulator_model

// [verilog/arb_node_sequencer.sv]
// What this block does
// (RULE1) Zero duration marks the last node of a waveform.
// (RULE2) At the last node halt, or restart at start node if repeating.
// (RULE3) A waveform may start right after a terminal node.
// (RULE4) A run starts at the configured start node.
// (RULE5) Repeating: one tick from terminal voltage to start voltage.
// (RULE6) No terminal node, no repeat: stop at position 60.
// (RULE7) No terminal node, repeat: interpolate from 60 to 1.
// (RULE8) Reset loads a ten-node pulse per range; rest zero.
// (RULE9) A restore pulse rewrites nodes 1 to 10 to factory values.
// (RULE10) A run emits a fresh setpoint every tick; stalled ticks merge, and a tick pending in check or divide is dropped if the buffer has room.
// (RULE11) Nodes hold voltage and 0 to 4095 ms; 60 per range.
// (RULE12) Steps are whole 10 mV units; remainders carry extra units.
// (RULE13) The last step lands on the next node voltage.
// (RULE14) After a node's duration the index advances, 60 wraps to 1.
`timescale 1ns/1ps
module arb_node_sequencer #(
    parameter int unsigned TICK_COUNT = arb_seq_pkg::TICK_CYCLES
) (
    input  wire logic                           clock,          // 250 MHz
    input  wire logic                           reset_n,        // Async, low
    input  wire logic                           start,          // Run pulse
    input  wire logic                           stop,           // Halt pulse
    input  wire logic                           repeatOn,       // Repeat mode
    input  wire logic                           rangeSel,       // 1 = high
    input  wire logic [arb_seq_pkg::IDX_W-1:0]  startNode,      // 0 = pos 1
    input  wire logic                           restoreDefaults,// Pulse
    input  wire logic                           wrEn,           // Table write
    input  wire logic                           wrRange,        // Write range
    input  wire logic [arb_seq_pkg::IDX_W-1:0]  wrNode,         // Write index
    input  wire logic [arb_seq_pkg::VOLT_W-1:0] wrVoltage,      // 10 mV units
    input  wire logic [arb_seq_pkg::DUR_W-1:0]  wrDuration,     // ms
    output logic [arb_seq_pkg::VOLT_W-1:0]      setpoint,       // To regulator
    output logic                                setpointValid,  // Word valid
    input  wire logic                           setpointReady,  // Taken
    output logic                                running,        // Active
    output logic [arb_seq_pkg::IDX_W-1:0]       nodePosition    // Current node
);
    import arb_seq_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Node table
    logic [VOLT_W-1:0] nodeVoltage_reg  [RANGE_COUNT][NODE_COUNT];
    logic [VOLT_W-1:0] nodeVoltage_next [RANGE_COUNT][NODE_COUNT];
    logic [DUR_W-1:0]  nodeDuration_reg  [RANGE_COUNT][NODE_COUNT];
    logic [DUR_W-1:0]  nodeDuration_next [RANGE_COUNT][NODE_COUNT];

    // Sequencer state
    seq_state_t        state_reg, state_next;
    logic [IDX_W-1:0]  idx_reg, idx_next;
    logic [IDX_W-1:0]  startIdx_reg, startIdx_next;
    logic              range_reg, range_next;
    logic              repeat_reg, repeat_next;
    logic [VOLT_W-1:0] curVolt_reg, curVolt_next;
    logic [VOLT_W-1:0] target_reg, target_next;
    logic              down_reg, down_next;
    logic [DUR_W-1:0]  stepCnt_reg, stepCnt_next;
    logic [DUR_W:0]    errAcc_reg, errAcc_next;
    logic [VOLT_W:0]   divRem_reg, divRem_next;
    logic [VOLT_W-1:0] divQuo_reg, divQuo_next;
    logic [3:0]        divCnt_reg, divCnt_next;
    logic [TICK_W-1:0] tickCnt_reg, tickCnt_next;
    logic              tickPend_reg, tickPend_next;
    logic              running_reg, running_next;

    // Combinational helpers
    logic              fifoReady, pushValid, step, tick, carry;
    logic [VOLT_W-1:0] pushData, nodeVolt, nextVolt, stepSize;
    logic [DUR_W-1:0]  nodeDur;
    logic [IDX_W-1:0]  nextIdx, startClamp;
    logic [VOLT_W:0]   trial;
    logic [DUR_W:0]    accSum;

    ////////////////////////////////////////////////////////////////////////
    // Restore first; a write beats it
    always_comb begin
        nodeVoltage_next  = nodeVoltage_reg;
        nodeDuration_next = nodeDuration_reg;
        if (restoreDefaults) begin
            for (int r = 0; r < RANGE_COUNT; r++) begin
                for (int i = 0; i < DEFAULT_NODES; i++) begin
                    nodeVoltage_next[r][i]  = defaultVoltage(r[0], i); // RULE9
                    nodeDuration_next[r][i] = defaultDuration(r[0],i); // RULE9
                end
            end
        end
        // Writes past position 60 are dropped
        if (wrEn && wrNode <= LAST_NODE) begin
            nodeVoltage_next[wrRange][wrNode]  = wrVoltage;
            nodeDuration_next[wrRange][wrNode] = wrDuration; // RULE11
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int r = 0; r < RANGE_COUNT; r++) begin
                for (int i = 0; i < NODE_COUNT; i++) begin
                    nodeVoltage_reg[r][i]  <= defaultVoltage(r[0], i); // RULE8
                    nodeDuration_reg[r][i] <= defaultDuration(r[0],i); // RULE8
                end
            end
        end else begin
            nodeVoltage_reg  <= nodeVoltage_next;
            nodeDuration_reg <= nodeDuration_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Current and following node
    assign nextIdx  = (idx_reg == LAST_NODE) ? FIRST_NODE : idx_reg + 1'b1;
    assign nodeVolt = nodeVoltage_reg[range_reg][idx_reg];
    assign nodeDur  = nodeDuration_reg[range_reg][idx_reg];
    assign nextVolt = nodeVoltage_reg[range_reg][nextIdx];
    assign startClamp = (startNode > LAST_NODE) ? FIRST_NODE : startNode;

    // Ticks wait for buffer room; ticks during a stall merge into one pending tick
    assign tick = (tickCnt_reg == TICK_W'(TICK_COUNT - 1));
    assign step = tickPend_reg && fifoReady;

    // Divider round and carry
    assign trial    = {divRem_reg[VOLT_W-1:0], divQuo_reg[VOLT_W-1]};
    assign accSum   = errAcc_reg + {1'b0, divRem_reg[DUR_W-1:0]};
    assign carry    = accSum >= {1'b0, nodeDur};
    assign stepSize = divQuo_reg + VOLT_W'(carry);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        state_next    = state_reg;
        idx_next      = idx_reg;
        startIdx_next = startIdx_reg;
        range_next    = range_reg;
        repeat_next   = repeat_reg;
        curVolt_next  = curVolt_reg;
        target_next   = target_reg;
        down_next     = down_reg;
        stepCnt_next  = stepCnt_reg;
        errAcc_next   = errAcc_reg;
        divRem_next   = divRem_reg;
        divQuo_next   = divQuo_reg;
        divCnt_next   = divCnt_reg;
        pushValid     = 1'b0;
        pushData      = curVolt_reg;
        tickCnt_next  = tick ? '0 : tickCnt_reg + 1'b1;
        // Set wins over clear
        tickPend_next = tick || (tickPend_reg && !step);
        unique case (state_reg)
            ST_IDLE: begin
                tickCnt_next  = '0;
                tickPend_next = 1'b0;
            end
            ST_WAIT: begin
                if (step) begin
                    pushValid    = 1'b1; // RULE10
                    pushData     = nodeVolt;
                    curVolt_next = nodeVolt;
                    state_next   = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (nodeDur == DUR_ZERO) begin // RULE1
                    if (repeat_reg) begin
                        // Next tick emits the start voltage
                        idx_next   = startIdx_reg; // RULE2 RULE5
                        state_next = ST_WAIT;
                    end else begin
                        state_next = ST_IDLE; // RULE2
                    end
                end else if (idx_reg == LAST_NODE && !repeat_reg) begin
                    state_next = ST_IDLE; // RULE6
                end else begin
                    target_next = nextVolt; // RULE7
                    down_next   = nextVolt < curVolt_reg;
                    divQuo_next = down_next ? curVolt_reg - nextVolt
                                            : nextVolt - curVolt_reg;
                    divRem_next = '0;
                    divCnt_next = '0;
                    state_next  = ST_DIV;
                end
            end
            ST_DIV: begin
                // One quotient bit per cycle; a pending tick is cleared here without a push if the buffer has room
                if (trial >= {1'b0, nodeDur}) begin
                    divRem_next = trial - {1'b0, nodeDur};
                    divQuo_next = {divQuo_reg[VOLT_W-2:0], 1'b1};
                end else begin
                    divRem_next = trial;
                    divQuo_next = {divQuo_reg[VOLT_W-2:0], 1'b0};
                end
                divCnt_next = divCnt_reg + 1'b1;
                if (divCnt_reg == DIV_LAST) begin
                    stepCnt_next = 12'h001;
                    errAcc_next  = '0;
                    state_next   = ST_RUN;
                end
            end
            ST_RUN: begin
                if (step) begin
                    pushValid = 1'b1; // RULE10
                    if (stepCnt_reg == nodeDur) begin
                        pushData     = target_reg; // RULE13
                        curVolt_next = target_reg; // RULE13
                        idx_next     = nextIdx; // RULE14
                        state_next   = ST_CHECK;
                    end else begin
                        pushData = down_reg ? curVolt_reg - stepSize
                                            : curVolt_reg + stepSize; // RULE12
                        curVolt_next = pushData;
                        errAcc_next  = carry ? accSum - {1'b0, nodeDur}
                                             : accSum; // RULE12
                        stepCnt_next = stepCnt_reg + 1'b1;
                    end
                end
            end
        endcase
        // Start restarts a run; stop wins
        if (start) begin
            idx_next      = startClamp; // RULE4 RULE3
            startIdx_next = startClamp; // RULE4
            range_next    = rangeSel;
            repeat_next   = repeatOn;
            tickCnt_next  = '0;
            tickPend_next = 1'b0;
            state_next    = ST_WAIT;
        end
        if (stop) begin
            state_next = ST_IDLE;
        end
        running_next = (state_next != ST_IDLE);
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg    <= ST_IDLE;
            idx_reg      <= FIRST_NODE;
            startIdx_reg <= FIRST_NODE;
            range_reg    <= 1'b0;
            repeat_reg   <= 1'b0;
            curVolt_reg  <= VOLT_ZERO;
            target_reg   <= VOLT_ZERO;
            down_reg     <= 1'b0;
            stepCnt_reg  <= '0;
            errAcc_reg   <= '0;
            divRem_reg   <= '0;
            divQuo_reg   <= '0;
            divCnt_reg   <= '0;
            tickCnt_reg  <= '0;
            tickPend_reg <= 1'b0;
            running_reg  <= 1'b0;
        end else begin
            state_reg    <= state_next;
            idx_reg      <= idx_next;
            startIdx_reg <= startIdx_next;
            range_reg    <= range_next;
            repeat_reg   <= repeat_next;
            curVolt_reg  <= curVolt_next;
            target_reg   <= target_next;
            down_reg     <= down_next;
            stepCnt_reg  <= stepCnt_next;
            errAcc_reg   <= errAcc_next;
            divRem_reg   <= divRem_next;
            divQuo_reg   <= divQuo_next;
            divCnt_reg   <= divCnt_next;
            tickCnt_reg  <= tickCnt_next;
            tickPend_reg <= tickPend_next;
            running_reg  <= running_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Setpoint buffer
    setpoint_fifo #(
        .WIDTH (VOLT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock    (clock),
        .reset_n  (reset_n),
        .inValid  (pushValid),
        .inReady  (fifoReady),
        .inData   (pushData),
        .outValid (setpointValid),
        .outReady (setpointReady),
        .outData  (setpoint)
    );

    assign running      = running_reg;
    assign nodePosition = idx_reg;

endmodule : arb_node_sequencer

// [verilog/arb_seq_pkg.sv]
package arb_seq_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Table geometry
    localparam int unsigned NODE_COUNT    = 60;   // Positions per range
    localparam int unsigned RANGE_COUNT   = 2;    // Low and high range
    localparam int unsigned DEFAULT_NODES = 10;   // Nodes with a default pulse
    localparam int unsigned IDX_W         = 6;    // Node index width
    localparam int unsigned VOLT_W        = 12;   // Voltage, 10 mV units
    localparam int unsigned DUR_W         = 12;   // Duration, 1 ms units

    localparam logic [IDX_W-1:0]  LAST_NODE = 6'h3b;   // Position 60
    localparam logic [IDX_W-1:0]  FIRST_NODE = 6'h00;  // Position 1
    localparam logic [DUR_W-1:0]  DUR_ZERO  = 12'h000; // Terminal marker
    localparam logic [VOLT_W-1:0] VOLT_ZERO = 12'h000; // 0.00 V

    ////////////////////////////////////////////////////////////////////////
    // Factory voltages in 10 mV units
    localparam logic [VOLT_W-1:0] V_6_00  = 12'h258;  // 6.00 V
    localparam logic [VOLT_W-1:0] V_7_00  = 12'h2bc;  // 7.00 V
    localparam logic [VOLT_W-1:0] V_8_00  = 12'h320;  // 8.00 V
    localparam logic [VOLT_W-1:0] V_12_00 = 12'h4b0;  // 12.00 V
    localparam logic [VOLT_W-1:0] V_24_00 = 12'h960;  // 24.00 V

    // Factory durations in ms
    localparam logic [DUR_W-1:0] T_5   = 12'h005;
    localparam logic [DUR_W-1:0] T_10  = 12'h00a;
    localparam logic [DUR_W-1:0] T_15  = 12'h00f;
    localparam logic [DUR_W-1:0] T_50  = 12'h032;
    localparam logic [DUR_W-1:0] T_100 = 12'h064;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned CLOCK_PERIOD_PS = 4000;      // 250 MHz
    localparam int unsigned TICK_PERIOD_PS  = 1000000000; // 1 ms
    localparam int unsigned TICK_CYCLES =
        TICK_PERIOD_PS / CLOCK_PERIOD_PS;                // Cycles per ms
    localparam int unsigned TICK_W      = 18;            // Tick counter
    localparam int unsigned DIV_STEPS   = VOLT_W;        // Divider rounds
    localparam logic [3:0]  DIV_LAST    = 4'hb;          // Last round index

    localparam int unsigned FIFO_DEPTH  = 16;            // Setpoint buffer

    // Sequencer states, Gray along idle-wait-check-divide-run
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_WAIT  = 3'h1,
        ST_CHECK = 3'h3,
        ST_DIV   = 3'h2,
        ST_RUN   = 3'h6
    } seq_state_t;

    // Factory voltage of a node
    function automatic logic [VOLT_W-1:0] defaultVoltage(
        input logic highRange, input int unsigned idx);
        logic [VOLT_W-1:0] v;
        v = VOLT_ZERO;
        if (idx == 0 || idx == 9)
            v = highRange ? V_24_00 : V_12_00;
        else if (idx == 1 || idx == 2)
            v = highRange ? V_8_00 : V_6_00;
        else if (idx >= 3 && idx <= 8)
            v = highRange ? V_12_00 : V_7_00;
        return v;
    endfunction : defaultVoltage

    // Factory duration of a node
    function automatic logic [DUR_W-1:0] defaultDuration(
        input logic highRange, input int unsigned idx);
        logic [DUR_W-1:0] t;
        t = DUR_ZERO;
        if (idx == 0)
            t = highRange ? T_10 : T_5;
        else if (idx == 1)
            t = highRange ? T_50 : T_15;
        else if (idx == 2)
            t = T_50;
        else if (idx >= 3 && idx <= 7)
            t = T_100;
        else if (idx == 8)
            t = highRange ? T_10 : T_100;
        return t;
    endfunction : defaultDuration

endpackage : arb_seq_pkg

// [verilog/setpoint_fifo.sv]
`timescale 1ns/1ps
module setpoint_fifo #(
    parameter int unsigned WIDTH = 12,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clock,    // Clock
    input  wire logic             reset_n,  // Async reset
    input  wire logic             inValid,  // Push
    output logic                  inReady,  // Room left
    input  wire logic [WIDTH-1:0] inData,   // Push word
    output logic                  outValid, // Word waiting
    input  wire logic             outReady, // Word taken
    output logic [WIDTH-1:0]      outData   // Oldest word
);
    localparam int unsigned PTR_W = $clog2(DEPTH);
    localparam int unsigned CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR   = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [PTR_W-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
    logic [CNT_W-1:0] count_reg, count_next;
    logic             outValid_reg, outValid_next;
    logic [WIDTH-1:0] outData_reg, outData_next;
    logic             doWrite, doRead;

    ////////////////////////////////////////////////////////////////////////
    // Output stage registered
    always_comb begin
        doWrite       = inValid && inReady;
        doRead        = (count_reg != '0) && (!outValid_reg || outReady);
        mem_next      = mem_reg;
        wrPtr_next    = wrPtr_reg;
        rdPtr_next    = rdPtr_reg;
        outValid_next = outValid_reg && !outReady;
        outData_next  = outData_reg;
        if (doWrite) begin
            mem_next[wrPtr_reg] = inData;
            wrPtr_next = (wrPtr_reg == LAST_PTR) ? '0 : wrPtr_reg + 1'b1;
        end
        if (doRead) begin
            outData_next  = mem_reg[rdPtr_reg];
            outValid_next = 1'b1;
            rdPtr_next = (rdPtr_reg == LAST_PTR) ? '0 : rdPtr_reg + 1'b1;
        end
        count_next = count_reg + CNT_W'(doWrite) - CNT_W'(doRead);
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mem_reg      <= '{default: '0};
            wrPtr_reg    <= '0;
            rdPtr_reg    <= '0;
            count_reg    <= '0;
            outValid_reg <= 1'b0;
            outData_reg  <= '0;
        end else begin
            mem_reg      <= mem_next;
            wrPtr_reg    <= wrPtr_next;
            rdPtr_reg    <= rdPtr_next;
            count_reg    <= count_next;
            outValid_reg <= outValid_next;
            outData_reg  <= outData_next;
        end
    end

    // Output word is not counted in full
    assign inReady  = (count_reg != FULL_COUNT);
    assign outValid = outValid_reg;
    assign outData  = outData_reg;

endmodule : setpoint_fifo
